/* core/pld_lock_core.sv */
// PLL reference and feedback dividers, digital lock detector, pin muxes and registers
// Notes on behaviour
// - Three-bit delay cell on each divider output
// - Lock judged from rising edge time difference
// - Unlock threshold wider than lock threshold
// - Lock after programmable consecutive in-window cycles
// - Single cycle beyond unlock window drops lock
// - Window from select bit and antibacklash; run length from count select
// - Lock selectable on all three pin muxes
// - Fixed divide with B one gives P
// - Fixed divide ignores A counter
// - Pull-down analog lock idles high, low pulses
// - Pull-up analog lock idles low, high pulses
// - Dual-modulus feedback with B above one divides by P times B plus A
// - Fourteen-bit reference divider, zero or one bypass
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
module pld_lock_core (
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    input  wire logic                        ref_in,
    input  wire logic                        vco_in,
    input  wire logic [pld_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [pld_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [pld_pkg::DATA_W-1:0]  reg_rdata,
    output logic                             irq,
    output logic                             lock_out_pin_o,
    output logic                             lock_out_pin_oe_n,
    output logic                             status_pin,
    output logic                             reference_monitor_pin
);
    import pld_pkg::*;

    typedef enum logic [1:0] {PM_IDLE, PM_REF_FIRST, PM_FB_FIRST} pld_meas_state_t;

    logic [13:0]     rdiv;
    pld_ndiv_cfg_t   ndiv;
    pld_lock_cfg_t   lock_cfg;
    pld_pin_cfg_t    pin;
    logic [2:0]      ref_dly;
    logic [2:0]      fb_dly;
    logic [1:0]      irq_st;
    logic [1:0]      irq_mask;

    logic            ref_q;
    logic            vco_q;
    logic [13:0]     ref_cnt;
    logic [18:0]     fb_cnt;
    logic            ref_pulse;
    logic            fb_pulse;
    logic            ref_d;
    logic            fb_d;

    pld_meas_state_t state;
    pld_meas_state_t next_state;
    logic [7:0]      meas_cnt;
    logic [7:0]      next_cnt;
    logic            eval_valid;
    logic [7:0]      eval_diff;
    logic [7:0]      run_cnt;
    logic [7:0]      next_run;
    logic            digital_lock_indicator;
    logic            next_lock;

    // Register decode
    wire wr_rdiv = reg_wr && (reg_addr == ADDR_RDIV);
    wire wr_ndiv = reg_wr && (reg_addr == ADDR_NDIV);
    wire wr_lock = reg_wr && (reg_addr == ADDR_LOCK);
    wire wr_dly  = reg_wr && (reg_addr == ADDR_DLY);
    wire wr_pin  = reg_wr && (reg_addr == ADDR_PIN);
    wire wr_irq  = reg_wr && (reg_addr == ADDR_IRQ);
    wire wr_mask = reg_wr && (reg_addr == ADDR_MASK);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdiv     <= RDIV_RST;
            ndiv     <= '{mode: dual_modulus_mode_2, a: NA_RST, b: NB_RST};
            lock_cfg <= '0;
            pin      <= '0;
            ref_dly  <= 3'h0;
            fb_dly   <= 3'h0;
            irq_mask <= 2'h0;
        end else begin
            if (wr_rdiv) rdiv <= reg_wdata[13:0];
            if (wr_ndiv) begin
                ndiv.b    <= reg_wdata[NDIV_B_LSB +: 13];
                ndiv.a    <= reg_wdata[NDIV_A_LSB +: 6];
                ndiv.mode <= pld_presc_mode_t'(reg_wdata[NDIV_MODE_LSB +: 3]);
            end
            if (wr_lock) begin
                lock_cfg.abl     <= reg_wdata[LOCK_ABL_LSB +: 2];
                lock_cfg.wide    <= reg_wdata[LOCK_WIN_BIT];
                lock_cfg.run_sel <= reg_wdata[LOCK_CNT_LSB +: 2];
            end
            if (wr_dly) begin
                ref_dly <= reg_wdata[DLY_REF_LSB +: 3];
                fb_dly  <= reg_wdata[DLY_FB_LSB +: 3];
            end
            if (wr_pin) begin
                pin.lock_out <= reg_wdata[PIN_LOCK_LSB +: 2];
                pin.status   <= reg_wdata[PIN_STAT_LSB +: 2];
                pin.monitor  <= reg_wdata[PIN_MON_LSB +: 2];
            end
            if (wr_mask) irq_mask <= reg_wdata[1:0];
        end
    end

    // Inputs are synchronous, so a one-flop history is enough for edges
    wire ref_rise = ref_in && !ref_q;
    wire vco_rise = vco_in && !vco_q;

    // zero and one both divide by one
    wire [13:0] r_eff   = (rdiv <= 14'h0001) ? 14'h0001 : rdiv;
    wire [18:0] n_total = pld_n_total(ndiv);

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ref_q     <= 1'b0;
            vco_q     <= 1'b0;
            ref_cnt   <= 14'h0000;
            fb_cnt    <= 19'h00000;
            ref_pulse <= 1'b0;
            fb_pulse  <= 1'b0;
        end else begin
            ref_q     <= ref_in;
            vco_q     <= vco_in;
            ref_pulse <= 1'b0;
            fb_pulse  <= 1'b0;
            if (ref_rise) begin
                ref_pulse <= (ref_cnt >= r_eff - 14'h0001);
                ref_cnt   <= (ref_cnt >= r_eff - 14'h0001) ? 14'h0000 : ref_cnt + 14'h0001;
            end
            if (vco_rise) begin
                fb_pulse <= (fb_cnt >= n_total - 19'h00001);
                fb_cnt   <= (fb_cnt >= n_total - 19'h00001) ? 19'h00000 : fb_cnt + 19'h00001;
            end
        end
    end

    // delay cells on both divider outputs
    pld_delay_cell #(.STAGES(DLY_STAGES)) u_ref_dly (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .code     (ref_dly),
        .pulse_in (ref_pulse),
        .pulse_out(ref_d)
    );
    pld_delay_cell #(.STAGES(DLY_STAGES)) u_fb_dly (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .code     (fb_dly),
        .pulse_in (fb_pulse),
        .pulse_out(fb_d)
    );

    // window from select bit and antibacklash
    wire [7:0] abl_add    = {6'h00, lock_cfg.abl} * ABL_STEP_CYC;
    wire [7:0] lock_thr   = (lock_cfg.wide ? LOCK_WIDE_CYC : LOCK_NARROW_CYC) + abl_add;
    wire [7:0] unlock_thr = (lock_cfg.wide ? UNLOCK_WIDE_CYC : UNLOCK_NARROW_CYC) + abl_add;
    wire [7:0] run_target = (lock_cfg.run_sel == 2'h0) ? RUN_CNT_0 :
                            (lock_cfg.run_sel == 2'h1) ? RUN_CNT_1 :
                            (lock_cfg.run_sel == 2'h2) ? RUN_CNT_2 : RUN_CNT_3;

    always_comb begin
        next_state = state;
        next_cnt   = meas_cnt;
        eval_valid = 1'b0;
        eval_diff  = meas_cnt;
        case (state)
            PM_IDLE: begin
                eval_diff = 8'h00;
                if (ref_d && fb_d) begin
                    eval_valid = 1'b1;
                end else if (ref_d) begin
                    next_state = PM_REF_FIRST;
                    next_cnt   = 8'h01;
                end else if (fb_d) begin
                    next_state = PM_FB_FIRST;
                    next_cnt   = 8'h01;
                end
            end
            // A missing partner edge past the unlock window counts as an unlock cycle
            PM_REF_FIRST: begin
                if (fb_d || meas_cnt > unlock_thr) begin
                    eval_valid = 1'b1;
                    next_state = PM_IDLE;
                    next_cnt   = 8'h00;
                end else begin
                    next_cnt = meas_cnt + 8'h01;
                end
            end
            PM_FB_FIRST: begin
                if (ref_d || meas_cnt > unlock_thr) begin
                    eval_valid = 1'b1;
                    next_state = PM_IDLE;
                    next_cnt   = 8'h00;
                end else begin
                    next_cnt = meas_cnt + 8'h01;
                end
            end
            default: begin
                next_state = PM_IDLE;
                next_cnt   = 8'h00;
            end
        endcase
    end

    wire eval_in_lock  = eval_diff < lock_thr;
    wire eval_out_lock = eval_diff > unlock_thr;

    // any cycle outside the lock window restarts the run
    assign next_run = !eval_valid ? run_cnt :
                      !eval_in_lock ? 8'h00 :
                      (run_cnt == 8'hff) ? run_cnt : run_cnt + 8'h01;

    wire lock_grant = eval_valid && eval_in_lock && (next_run >= run_target);

    assign next_lock = (eval_valid && eval_out_lock) ? 1'b0 :
                       lock_grant ? 1'b1 : digital_lock_indicator;

    wire evt_acq  = next_lock && !digital_lock_indicator;
    wire evt_lost = !next_lock && digital_lock_indicator;

    // Set wins over a write-one clear in the same cycle
    wire [1:0] irq_clr     = wr_irq ? reg_wdata[1:0] : 2'h0;
    wire [1:0] irq_evt     = {evt_lost, evt_acq};
    wire [1:0] next_irq_st = (irq_st & ~irq_clr) | irq_evt;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state                  <= PM_IDLE;
            meas_cnt               <= 8'h00;
            run_cnt                <= 8'h00;
            digital_lock_indicator <= 1'b0;
            irq_st                 <= 2'h0;
        end else begin
            state                  <= next_state;
            meas_cnt               <= next_cnt;
            run_cnt                <= next_run;
            digital_lock_indicator <= next_lock;
            irq_st                 <= next_irq_st;
        end
    end

    // Analog indicator pulses while the edges are apart
    wire analog_lock_indicator = (state != PM_IDLE);

    // pull-down mode releases pin, pulses low
    // pull-up mode releases pin, pulses high
    wire next_lock_o    = (pin.lock_out == LPIN_DIGITAL) ? digital_lock_indicator :
                          (pin.lock_out == LPIN_PULLUP);
    wire next_lock_oe_n = (pin.lock_out == LPIN_PULLDOWN ||
                           pin.lock_out == LPIN_PULLUP) ? !analog_lock_indicator : 1'b0;

    // lock is a source in each pin mux
    wire next_status  = (pin.status == AUX_LOCK) ? digital_lock_indicator :
                        (pin.status == AUX_REF_DIV) ? ref_d :
                        (pin.status == AUX_FB_DIV) ? fb_d : 1'b0;
    wire next_monitor = (pin.monitor == AUX_LOCK) ? digital_lock_indicator :
                        (pin.monitor == AUX_REF_DIV) ? ref_d :
                        (pin.monitor == AUX_FB_DIV) ? fb_d : 1'b0;

    wire [31:0] rd_word =
        (reg_addr == ADDR_RDIV) ? {18'h00000, rdiv} :
        (reg_addr == ADDR_NDIV) ? {5'h00, ndiv.mode, 2'h0, ndiv.a, 3'h0, ndiv.b} :
        (reg_addr == ADDR_LOCK) ? {25'h0000000, lock_cfg.run_sel, lock_cfg.wide, 2'h0,
                                   lock_cfg.abl} :
        (reg_addr == ADDR_DLY)  ? {25'h0000000, fb_dly, 1'h0, ref_dly} :
        (reg_addr == ADDR_PIN)  ? {22'h000000, pin.monitor, 2'h0, pin.status, 2'h0,
                                   pin.lock_out} :
        (reg_addr == ADDR_STAT) ? {16'h0000, run_cnt, 7'h00, digital_lock_indicator} :
        (reg_addr == ADDR_IRQ)  ? {30'h00000000, irq_st} :
        (reg_addr == ADDR_MASK) ? {30'h00000000, irq_mask} : 32'h00000000;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reg_rdata             <= 32'h00000000;
            irq                   <= 1'b0;
            lock_out_pin_o        <= 1'b0;
            lock_out_pin_oe_n     <= 1'b1;
            status_pin            <= 1'b0;
            reference_monitor_pin <= 1'b0;
        end else begin
            reg_rdata             <= reg_rd ? rd_word : 32'h00000000;
            irq                   <= |(irq_st & irq_mask);
            lock_out_pin_o        <= next_lock_o;
            lock_out_pin_oe_n     <= next_lock_oe_n;
            status_pin            <= next_status;
            reference_monitor_pin <= next_monitor;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence seq_ref_lead;
        state == PM_IDLE && ref_d && !fb_d && unlock_thr >= 8'h03;
    endsequence
    sequence seq_fb_after_three;
        !fb_d [*2] ##1 fb_d;
    endsequence

    chk_edge_diff_three: assert property (seq_ref_lead ##1 seq_fb_after_three |->
        eval_valid && eval_diff == 8'h03)
        else $error("edge difference not measured as three clocks");
    chk_window_order: assert property (unlock_thr > lock_thr)
        else $error("unlock threshold not wider than lock threshold");
    chk_lock_rise_cause: assert property ($rose(digital_lock_indicator) |->
        $past(lock_grant))
        else $error("lock rose without a full in-window run");
    chk_unlock_drop: assert property (eval_valid && eval_out_lock |=>
        !digital_lock_indicator)
        else $error("lock kept after an unlock cycle");
    chk_lock_hold: assert property (digital_lock_indicator && !(eval_valid && eval_out_lock)
        |=> digital_lock_indicator)
        else $error("lock dropped without an unlock cycle");
    chk_window_select: assert property (lock_cfg.wide && lock_cfg.abl == 2'h0 |->
        lock_thr == LOCK_WIDE_CYC && unlock_thr == UNLOCK_WIDE_CYC)
        else $error("wide window thresholds wrong");
    chk_pin_lock_route: assert property (pin.status == AUX_LOCK |=>
        status_pin == $past(digital_lock_indicator))
        else $error("status pin does not follow lock");
    chk_fd_bypass: assert property (ndiv.mode == fixed_divide_mode_2 && ndiv.b == 13'h0001
        |-> n_total == 19'h00002)
        else $error("bypass divide not equal to prescaler");
    chk_fd_no_a: assert property (ndiv.mode == fixed_divide_mode_3 && ndiv.b == 13'h0004
        |-> n_total == 19'h0000c)
        else $error("fixed divide used the A counter");
    chk_pulldown_idle: assert property (pin.lock_out == LPIN_PULLDOWN &&
        state == PM_IDLE |=> lock_out_pin_oe_n && !lock_out_pin_o)
        else $error("pull-down analog pin not released when idle");
    chk_pullup_pulse: assert property (pin.lock_out == LPIN_PULLUP &&
        state != PM_IDLE |=> !lock_out_pin_oe_n && lock_out_pin_o)
        else $error("pull-up analog pin not pulsing high");
    chk_rdiv_by_one: assert property (rdiv <= 14'h0001 && ref_rise |=> ref_pulse)
        else $error("reference divide by one missed an edge");
    chk_run_clear: assert property (eval_valid && !eval_in_lock |=> run_cnt == 8'h00)
        else $error("run counter not cleared");
endmodule
`default_nettype wire

/* include/pld_pkg.sv */
// Shared constants, types and divide-ratio helper for the PLL divider and lock detector
`default_nettype none
package pld_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int ADDR_W        = 8;
    localparam int DATA_W        = 32;

    localparam logic [7:0] ADDR_RDIV = 8'h00;
    localparam logic [7:0] ADDR_NDIV = 8'h04;
    localparam logic [7:0] ADDR_LOCK = 8'h08;
    localparam logic [7:0] ADDR_DLY  = 8'h0c;
    localparam logic [7:0] ADDR_PIN  = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ  = 8'h18;
    localparam logic [7:0] ADDR_MASK = 8'h1c;

    localparam int NDIV_B_LSB    = 0;
    localparam int NDIV_A_LSB    = 16;
    localparam int NDIV_MODE_LSB = 24;
    localparam int LOCK_ABL_LSB  = 0;
    localparam int LOCK_WIN_BIT  = 4;
    localparam int LOCK_CNT_LSB  = 5;
    localparam int DLY_REF_LSB   = 0;
    localparam int DLY_FB_LSB    = 4;
    localparam int PIN_LOCK_LSB  = 0;
    localparam int PIN_STAT_LSB  = 4;
    localparam int PIN_MON_LSB   = 8;
    localparam int IRQ_ACQ_BIT   = 0;
    localparam int IRQ_LOST_BIT  = 1;

    localparam logic [13:0] RDIV_RST = 14'h0001;
    localparam logic [12:0] NB_RST   = 13'h0003;
    localparam logic [5:0]  NA_RST   = 6'h00;

    // Threshold times; each must stay at least one clock
    localparam int LOCK_THR_NARROW_PS   = 8000;
    localparam int UNLOCK_THR_NARROW_PS = 16000;
    localparam int LOCK_THR_WIDE_PS     = 20000;
    localparam int UNLOCK_THR_WIDE_PS   = 32000;
    localparam int ABL_STEP_PS          = 4000;
    localparam logic [7:0] LOCK_NARROW_CYC   = 8'(LOCK_THR_NARROW_PS / CLK_PERIOD_PS);
    localparam logic [7:0] UNLOCK_NARROW_CYC = 8'(UNLOCK_THR_NARROW_PS / CLK_PERIOD_PS);
    localparam logic [7:0] LOCK_WIDE_CYC     = 8'(LOCK_THR_WIDE_PS / CLK_PERIOD_PS);
    localparam logic [7:0] UNLOCK_WIDE_CYC   = 8'(UNLOCK_THR_WIDE_PS / CLK_PERIOD_PS);
    localparam logic [7:0] ABL_STEP_CYC      = 8'(ABL_STEP_PS / CLK_PERIOD_PS);

    localparam logic [7:0] RUN_CNT_0 = 8'h05;
    localparam logic [7:0] RUN_CNT_1 = 8'h10;
    localparam logic [7:0] RUN_CNT_2 = 8'h40;
    localparam logic [7:0] RUN_CNT_3 = 8'hff;

    localparam int DLY_STAGES = 7;

    typedef enum logic [2:0] {
        fixed_divide_mode_1, fixed_divide_mode_2, fixed_divide_mode_3,
        dual_modulus_mode_2, dual_modulus_mode_4, dual_modulus_mode_8,
        dual_modulus_mode_16, dual_modulus_mode_32
    } pld_presc_mode_t;

    typedef enum logic [1:0] {LPIN_DIGITAL, LPIN_PULLDOWN, LPIN_PULLUP,
                              LPIN_LOW} pld_lock_pin_sel_t;
    typedef enum logic [1:0] {AUX_LOW, AUX_LOCK, AUX_REF_DIV, AUX_FB_DIV} pld_aux_sel_t;

    typedef struct packed {
        pld_presc_mode_t mode;
        logic [5:0]      a;
        logic [12:0]     b;
    } pld_ndiv_cfg_t;

    typedef struct packed {
        logic [1:0] run_sel;
        logic       wide;
        logic [1:0] abl;
    } pld_lock_cfg_t;

    typedef struct packed {
        logic [1:0] monitor;
        logic [1:0] status;
        logic [1:0] lock_out;
    } pld_pin_cfg_t;

    function automatic logic [5:0] pld_presc(input pld_presc_mode_t m);
        case (m)
            fixed_divide_mode_1:  return 6'h01;
            fixed_divide_mode_2:  return 6'h02;
            fixed_divide_mode_3:  return 6'h03;
            dual_modulus_mode_2:  return 6'h02;
            dual_modulus_mode_4:  return 6'h04;
            dual_modulus_mode_8:  return 6'h08;
            dual_modulus_mode_16: return 6'h10;
            default:              return 6'h20;
        endcase
    endfunction

    function automatic logic [18:0] pld_n_total(input pld_ndiv_cfg_t c);
        logic [18:0] p;
        p = {13'h0000, pld_presc(c.mode)};
        // B of one bypasses A and B
        if (c.b <= 13'h0001) begin
            return p;
        end
        if (c.mode <= fixed_divide_mode_3) begin
            return p * {6'h00, c.b};
        end
        // dual modulus P times B plus A
        return p * {6'h00, c.b} + {13'h0000, c.a};
    endfunction
endpackage
`default_nettype wire

/* core/pld_delay_cell.sv */
// Programmable three-bit delay cell for one divider output pulse
`timescale 1ns/1ns
`default_nettype none
module pld_delay_cell #(
    parameter int STAGES = pld_pkg::DLY_STAGES
) (
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    input  wire logic [2:0] code,
    input  wire logic       pulse_in,
    output logic            pulse_out
);
    import pld_pkg::*;

    logic [STAGES-1:0] taps;

    // Steps are whole clocks, far coarser than an analog cell
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            taps <= '0;
        end else begin
            taps <= {taps[STAGES-2:0], pulse_in};
        end
    end

    assign pulse_out = (code == 3'h0) ? pulse_in : taps[code - 3'h1];

    chk_dly_three_tap: assert property (@(posedge ref_clk) disable iff (!rstn)
        (pulse_in && code == 3'h3) |-> ##3 (pulse_out || code != 3'h3))
        else $error("delay cell did not delay pulse by three clocks");
endmodule
`default_nettype wire

/* tb/pld_clk_src.sv */
// Reference and feedback clock source with programmable phase lag
`timescale 1ns/1ns
`default_nettype none
module pld_clk_src (
    input  wire logic       ref_clk,
    input  wire logic [3:0] lag,
    output logic            ref_in = 1'b0,
    output logic            vco_in = 1'b0
);
    logic [3:0] phase = 4'h0;
    logic [3:0] lag_q = 4'h0;
    // counter input stays slow
    // Lag taken only at period end, so a change to a lag of eight or less never adds a feedback edge
    always @(posedge ref_clk) begin
        phase  <= phase + 4'h1;
        ref_in <= phase < 4'h8;
        vco_in <= 4'(phase - lag_q) < 4'h8;
        if (phase == 4'hf) begin
            lag_q <= lag;
        end
    end
endmodule
`default_nettype wire

/* tb/pld_lock_core_tb.sv */
// Register-driven bench for dividers, lock detector, pins and interrupt
`timescale 1ns/1ns
`default_nettype none
module pld_lock_core_tb;
    import pld_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        irq, lpin_o, lpin_oe_n, stat_pin, mon_pin, ref_in, vco_in;
    logic [3:0]  lag = 4'h0;
    logic [31:0] rd;
    logic [1:0]  drv_lv;
    int          failures = 0;
    int          tests_run = 0;
    int          n_ref, n_fb, n_drv;
    // Legal settings only: B of one or at least three, A not above B in dual modulus
    // A above B only in fixed divide or with B of one
    localparam logic [31:0] T_R [5] = '{32'h0, 32'h1, 32'h3, 32'h5, 32'h4};
    localparam logic [31:0] T_N [5] = '{32'h0005_0001, 32'h0100_0001, 32'h0209_0004,
                                        32'h0302_0004, 32'h0403_0003};
    localparam int          T_ER [5] = '{60, 60, 20, 12, 15};
    localparam int          T_EF [5] = '{60, 30, 5, 6, 4};

    pld_clk_src i_pld_clk_src (.ref_clk(ref_clk), .lag(lag), .ref_in(ref_in), .vco_in(vco_in));
    pld_lock_core i_pld_lock_core (
        .ref_clk(ref_clk), .rstn(rstn), .ref_in(ref_in), .vco_in(vco_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq), .lock_out_pin_o(lpin_o), .lock_out_pin_oe_n(lpin_oe_n),
        .status_pin(stat_pin), .reference_monitor_pin(mon_pin)
    );

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic lk(input logic e);
        rdr(ADDR_STAT);
        chk({31'h0, rd[0]}, {31'h0, e});
    endtask
    // Counts mux pulses and lock pin drive over a window
    task automatic sample(input int n);
        n_ref = 0;
        n_fb = 0;
        n_drv = 0;
        drv_lv = 2'b00;
        repeat (n) begin
            cyc(1);
            n_ref += int'(stat_pin === 1'b1);
            n_fb += int'(mon_pin === 1'b1);
            if (lpin_oe_n === 1'b0) begin
                n_drv++;
                drv_lv[lpin_o === 1'b1] = 1'b1;
            end
        end
    endtask
    task automatic conclude;
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge ref_clk);
        failures++;
        conclude();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rdr(ADDR_RDIV);
        chk(rd, 32'h1);
        rdr(ADDR_NDIV);
        chk(rd, 32'h0300_0003);
        rdr(8'h20);
        chk(rd, 32'h0);
        $display("test registers done");
        wr(ADDR_PIN, 32'h0000_0320);
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_RDIV, T_R[i]);
            wr(ADDR_NDIV, T_N[i]);
            cyc(300);
            sample(960);
            chk(32'(n_ref), 32'(T_ER[i]));
            chk(32'(n_fb), 32'(T_EF[i]));
        end
        $display("test dividers done");
        lag <= 4'h3;
        wr(ADDR_MASK, 32'h1);
        wr(ADDR_IRQ, 32'h3);
        wr(ADDR_RDIV, 32'h1);
        wr(ADDR_NDIV, 32'h0000_0001);
        wr(ADDR_PIN, 32'h0000_0110);
        cyc(200);
        lk(1'b0);
        wr(ADDR_DLY, 32'h3);
        cyc(200);
        lk(1'b1);
        chk({28'h0, stat_pin, mon_pin, lpin_o, lpin_oe_n}, 32'he);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_IRQ, 32'h1);
        cyc(3);
        chk({31'h0, irq}, 32'h0);
        $display("test lock done");
        lag <= 4'h7;
        cyc(200);
        lk(1'b1);
        lag <= 4'h8;
        cyc(40);
        lk(1'b0);
        rdr(ADDR_IRQ);
        chk(rd, 32'h2);
        chk({31'h0, irq}, 32'h0);
        wr(ADDR_MASK, 32'h3);
        cyc(3);
        chk({31'h0, irq}, 32'h1);
        $display("test unlock done");
        wr(ADDR_LOCK, 32'h10);
        cyc(200);
        lk(1'b0);
        wr(ADDR_LOCK, 32'h31);
        cyc(150);
        lk(1'b0);
        cyc(250);
        lk(1'b1);
        $display("test window done");
        wr(ADDR_PIN, 32'h1);
        sample(160);
        chk({30'h0, drv_lv}, 32'h1);
        chk(32'(n_drv > 0 && n_drv < 80), 32'h1);
        wr(ADDR_PIN, 32'h2);
        sample(160);
        chk({30'h0, drv_lv}, 32'h2);
        chk(32'(n_drv > 0 && n_drv < 80), 32'h1);
        wr(ADDR_PIN, 32'h3);
        sample(160);
        chk({30'h0, drv_lv}, 32'h1);
        chk(32'(n_drv), 32'ha0);
        $display("test analog done");
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        lk(1'b0);
        rdr(ADDR_NDIV);
        chk(rd, 32'h0300_0003);
        $display("test reset done");
        conclude();
    end
endmodule
`default_nettype wire
